// ---- core/sbp_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sbp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  import sbp_pkg::*;
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        rdy;
  } sbp_fifo_s;

  sbp_fifo_s st_r;
  sbp_fifo_s st_nxt;
  logic      push;
  logic      pop;

  always_comb begin
    push   = in_valid && (st_r.cnt != (AW+1)'(DEPTH));
    pop    = out_ready && (st_r.cnt != '0);
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp           = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // Ready kept in a flop so the port is registered
    st_nxt.rdy = st_nxt.cnt != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= '0;
      st_r.rdy <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready  = st_r.rdy;
  assign out_valid = st_r.cnt != '0;
  assign out_data  = st_r.mem[st_r.rp];
endmodule : sbp_fifo

// ---- core/sbp_pins.sv ----
// Bus data lines, byte parity and phase line pin logic
//
// Operation
// - Data lines carry ID, command, data, status, messages
// - Narrow transfers use only low byte lanes
// - Narrow: high byte undriven, receivers disabled
// - High parity is odd over bits 15:8
// - Narrow: high parity undriven, receiver disabled
// - Phase line sampled as initiator, driven as target
// - Target asserts phase line for command/status/message
// - Target direction line asserted toward initiator
// - Target message line asserted in message phase
`timescale 1ns/100ps
module sbp_pins #(
  parameter int DEPTH = sbp_pkg::FIFO_DEPTH
) (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      target_mode,
  input  wire logic                      wide_mode,
  input  wire logic                      xfer_out,
  input  wire logic [2:0]                tgt_phase,
  input  wire logic [sbp_pkg::DATA_W-1:0] tx_data,
  input  wire logic                      tx_valid,
  output logic                           tx_ready,
  output logic [sbp_pkg::DATA_W-1:0]     rx_data,
  output logic                           rx_valid,
  input  wire logic                      rx_ready,
  input  wire logic                      rx_sample,
  output logic                           parity_err,
  output logic [2:0]                     bus_phase,
  input  wire logic [sbp_pkg::DATA_W-1:0] bus_data_lines_in,
  output logic [sbp_pkg::DATA_W-1:0]     bus_data_lines_out,
  output logic [sbp_pkg::DATA_W-1:0]     bus_data_lines_oe_n,
  input  wire logic                      low_byte_parity_in,
  output logic                           low_byte_parity_out,
  output logic                           low_byte_parity_oe_n,
  input  wire logic                      high_byte_parity_in,
  output logic                           high_byte_parity_out,
  output logic                           high_byte_parity_oe_n,
  input  wire logic                      phase_cmd_data_line_in,
  output logic                           phase_cmd_data_line_out,
  output logic                           phase_cmd_data_line_oe_n,
  input  wire logic                      message_phase_line_in,
  output logic                           message_phase_line_out,
  output logic                           message_phase_line_oe_n,
  input  wire logic                      direction_line_in,
  output logic                           direction_line_out,
  output logic                           direction_line_oe_n
);
  import sbp_pkg::*;

  // Pin levels are active high here: 1 means the line is asserted
  typedef struct packed {
    sbp_state_e          state;
    logic [DATA_W-1:0]   d_s1;
    logic [DATA_W-1:0]   d_s2;
    logic [1:0]          p_s1;
    logic [1:0]          p_s2;
    logic [2:0]          c_s1;
    logic [2:0]          c_s2;
    logic [DATA_W-1:0]   dout;
    logic [DATA_W-1:0]   doe_n;
    logic                plo;
    logic                plo_oe_n;
    logic                phi;
    logic                phi_oe_n;
    logic [2:0]          ctl;
    logic                ctl_oe_n;
    logic [DATA_W-1:0]   rxd;
    logic                rxv;
    logic                perr;
    logic [2:0]          phase;
  } sbp_pins_s;

  sbp_pins_s         st_r;
  sbp_pins_s         st_nxt;
  logic [DATA_W-1:0] txf_data;
  logic              txf_valid;
  logic              txf_pop;
  logic              lo_bad;
  logic              hi_bad;

  // Outbound words wait here until the bus can drive them
  sbp_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_tx_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (txf_data),
    .out_valid (txf_valid),
    .out_ready (txf_pop)
  );

  always_comb begin
    st_nxt = st_r;
    txf_pop = 1'b0;
    // Two-stage synchronisers on every received pin
    st_nxt.d_s1 = bus_data_lines_in;
    st_nxt.d_s2 = st_r.d_s1;
    st_nxt.p_s1 = {high_byte_parity_in, low_byte_parity_in};
    st_nxt.p_s2 = st_r.p_s1;
    st_nxt.c_s1 = {message_phase_line_in, phase_cmd_data_line_in, direction_line_in};
    st_nxt.c_s2 = st_r.c_s1;

    // Control lines: driven as target, received as initiator
    st_nxt.ctl_oe_n = !target_mode;
    st_nxt.ctl      = target_mode ? tgt_phase : 3'h0;
    st_nxt.phase    = target_mode ? tgt_phase : st_r.c_s2;

    // Data path state machine; drives only when sending
    case (st_r.state)
      SBP_IDLE: begin
        st_nxt.doe_n    = '1;
        st_nxt.plo_oe_n = 1'b1;
        st_nxt.phi_oe_n = 1'b1;
        if (xfer_out && txf_valid) begin
          st_nxt.state = SBP_DRIVE;
        end
      end
      SBP_DRIVE: begin
        txf_pop          = 1'b1;
        st_nxt.dout      = txf_data;
        st_nxt.plo       = ~^txf_data[LO_MSB:0];
        st_nxt.plo_oe_n  = 1'b0;
        st_nxt.doe_n[LO_MSB:0] = '0;
        if (wide_mode) begin
          st_nxt.doe_n[DATA_W-1:HI_LSB] = '0;
          st_nxt.phi      = ~^txf_data[DATA_W-1:HI_LSB];
          st_nxt.phi_oe_n = 1'b0;
        end else begin
          st_nxt.doe_n[DATA_W-1:HI_LSB] = '1;
          st_nxt.dout[DATA_W-1:HI_LSB]  = '0;
          st_nxt.phi      = 1'b0;
          st_nxt.phi_oe_n = 1'b1;
        end
        st_nxt.state = SBP_HOLD;
      end
      SBP_HOLD: begin
        // Width may drop while a wide word still stands
        if (!wide_mode) begin
          st_nxt.doe_n[DATA_W-1:HI_LSB] = '1;
          st_nxt.dout[DATA_W-1:HI_LSB]  = '0;
          st_nxt.phi                    = 1'b0;
          st_nxt.phi_oe_n               = 1'b1;
        end
        if (!xfer_out) begin
          st_nxt.state = SBP_IDLE;
        end else if (txf_valid) begin
          st_nxt.state = SBP_DRIVE;
        end
      end
      default: begin
        st_nxt.state = SBP_IDLE;
      end
    endcase

    // Receive path: high byte ignored when narrow
    lo_bad = ~^{st_r.d_s2[LO_MSB:0], st_r.p_s2[0]};
    hi_bad = wide_mode && ~^{st_r.d_s2[DATA_W-1:HI_LSB], st_r.p_s2[1]};
    st_nxt.rxv = 1'b0;
    if (rx_sample && !xfer_out) begin
      st_nxt.rxd = wide_mode ? st_r.d_s2
                             : {{(DATA_W-BYTE_W){1'b0}}, st_r.d_s2[LO_MSB:0]};
      st_nxt.rxv  = 1'b1;
      st_nxt.perr = lo_bad || hi_bad;
    end else if (st_r.rxv && !rx_ready) begin
      st_nxt.rxv = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r          <= '0;
      st_r.state    <= SBP_IDLE;
      st_r.doe_n    <= '1;
      st_r.plo_oe_n <= 1'b1;
      st_r.phi_oe_n <= 1'b1;
      st_r.ctl_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus_data_lines_out       = st_r.dout;
  assign bus_data_lines_oe_n      = st_r.doe_n;
  assign low_byte_parity_out      = st_r.plo;
  assign low_byte_parity_oe_n     = st_r.plo_oe_n;
  assign high_byte_parity_out     = st_r.phi;
  assign high_byte_parity_oe_n    = st_r.phi_oe_n;
  assign message_phase_line_out   = st_r.ctl[PH_MSG_BIT];
  assign message_phase_line_oe_n  = st_r.ctl_oe_n;
  assign phase_cmd_data_line_out  = st_r.ctl[PH_CD_BIT];
  assign phase_cmd_data_line_oe_n = st_r.ctl_oe_n;
  assign direction_line_out       = st_r.ctl[PH_IO_BIT];
  assign direction_line_oe_n      = st_r.ctl_oe_n;
  assign rx_data                  = st_r.rxd;
  assign rx_valid                 = st_r.rxv;
  assign parity_err               = st_r.perr;
  assign bus_phase                = st_r.phase;
endmodule : sbp_pins

// ---- pkg/sbp_pkg.sv ----
// Constants and types for the bus data phase pin logic
package sbp_pkg;
  localparam int          DATA_W      = 16;
  localparam int          BYTE_W      = 8;
  localparam int          LO_MSB      = 7;
  localparam int          HI_LSB      = 8;
  localparam int          FIFO_DEPTH  = 4;
  localparam int          WORD_W      = 16;
  localparam logic [15:0] DATA_RST    = 16'h0000;
  localparam logic [1:0]  SYNC_RST    = 2'h0;
  // Phase codes {message, cmd_data, io}, asserted = 1
  localparam logic [2:0]  PH_DATA_OUT = 3'h0;
  localparam logic [2:0]  PH_DATA_IN  = 3'h1;
  localparam logic [2:0]  PH_CMD      = 3'h2;
  localparam logic [2:0]  PH_STATUS   = 3'h3;
  localparam logic [2:0]  PH_MSG_OUT  = 3'h6;
  localparam logic [2:0]  PH_MSG_IN   = 3'h7;
  localparam int          PH_MSG_BIT  = 2;
  localparam int          PH_CD_BIT   = 1;
  localparam int          PH_IO_BIT   = 0;

  typedef enum logic [1:0] {
    SBP_IDLE  = 2'b00,
    SBP_DRIVE = 2'b01,
    SBP_HOLD  = 2'b11
  } sbp_state_e;
endpackage : sbp_pkg

// ---- test/sbp_far_end.sv ----
// Far side device model on the shared bus
`timescale 1ns/100ps
module sbp_far_end (
  input wire logic        clock,
  input wire logic        drive,
  input wire logic [15:0] word,
  input wire logic        bad_lo,
  input wire logic        bad_hi,
  input wire logic [2:0]  phase,
  output logic     [15:0] d,
  output logic            lp,
  output logic            hp,
  output logic     [2:0]  po
);
  always_ff @(posedge clock) begin
    if (drive) begin
      d <= word;
      lp <= ~^word[7:0] ^ bad_lo;
      hp <= ~^word[15:8] ^ bad_hi;
    end else begin
      // Released lines rest deasserted on the terminated bus
      d <= '0;
      lp <= 1'b0;
      hp <= 1'b0;
    end
    po <= phase;
  end
endmodule : sbp_far_end

// ---- test/sbp_pins_bench.sv ----
// Self-checking bench for the bus data phase pin logic
`timescale 1ns/100ps
module sbp_pins_bench;
  import sbp_pkg::*;
  logic clock, rst_n, target_mode, wide_mode, xfer_out, tx_valid, tx_ready, rx_valid;
  logic rx_ready, rx_sample, parity_err, fdrv, fbl, fbh, flp, fhp;
  logic [15:0] tx_data, rx_data, bus_data_lines_in, bus_data_lines_out, bus_data_lines_oe_n;
  logic [15:0] fword, fd;
  logic [2:0] tgt_phase, bus_phase, fph, fpo;
  logic low_byte_parity_in, low_byte_parity_out, low_byte_parity_oe_n;
  logic high_byte_parity_in, high_byte_parity_out, high_byte_parity_oe_n;
  logic phase_cmd_data_line_in, phase_cmd_data_line_out, phase_cmd_data_line_oe_n;
  logic message_phase_line_in, message_phase_line_out, message_phase_line_oe_n;
  logic direction_line_in, direction_line_out, direction_line_oe_n;
  int err_count, check_count, i;
  localparam logic [2:0] PH [6] = '{PH_DATA_OUT, PH_DATA_IN, PH_CMD, PH_STATUS,
                                    PH_MSG_OUT, PH_MSG_IN};
  // Row: wide, bad low parity, bad high parity, word, parity error, received word
  logic [35:0] rows [4] = '{
    {3'b100, 16'ha55a, 1'b0, 16'ha55a},
    {3'b101, 16'ha55a, 1'b1, 16'ha55a},
    {3'b001, 16'h12c3, 1'b0, 16'h00c3},
    {3'b010, 16'h0081, 1'b1, 16'h0081}};
  assign bus_data_lines_in = (~bus_data_lines_oe_n & bus_data_lines_out)
                           | (bus_data_lines_oe_n & fd);
  assign low_byte_parity_in = low_byte_parity_oe_n ? flp : low_byte_parity_out;
  assign high_byte_parity_in = high_byte_parity_oe_n ? fhp : high_byte_parity_out;
  assign phase_cmd_data_line_in = phase_cmd_data_line_oe_n ? fpo[1] : phase_cmd_data_line_out;
  assign message_phase_line_in = message_phase_line_oe_n ? fpo[2] : message_phase_line_out;
  assign direction_line_in = direction_line_oe_n ? fpo[0] : direction_line_out;
  sbp_pins DUT (.*);
  sbp_far_end u_far (.clock(clock), .drive(fdrv), .word(fword), .bad_lo(fbl),
    .bad_hi(fbh), .phase(fph), .d(fd), .lp(flp), .hp(fhp), .po(fpo));
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #5000;
    err_count++;
    finish_test;
  end
  initial begin
    {rst_n, target_mode, wide_mode, xfer_out, tx_valid, rx_ready, rx_sample} = 0;
    {tgt_phase, fph, tx_data, fword, fbl, fbh} = 0;
    fdrv = 1;
    err_count = 0;
    check_count = 0;
    tick(2);
    rst_n <= 1;
    foreach (rows[r]) begin
      {wide_mode, fbl, fbh, fword} <= rows[r][35:17];
      tick(4);
      rx_sample <= 1;
      tick(1);
      rx_sample <= 0;
      for (i = 0; i < 10 && rx_valid !== 1'b1; i++) @(negedge clock);
      chk("rx_valid", 16'h1, {15'h0, rx_valid});
      chk("rx_data", rows[r][15:0], rx_data);
      chk("parity_err", {15'h0, rows[r][16]}, {15'h0, parity_err});
      tick(1);
      rx_ready <= 1;
      tick(1);
      rx_ready <= 0;
    end
    {target_mode, xfer_out, fdrv, tx_valid} <= 4'b1101;
    {wide_mode, tgt_phase, tx_data} <= {1'b0, PH_DATA_IN, 16'hbe5a};
    tick(1);
    {tx_valid, rx_sample} <= 2'b01;
    tick(1);
    rx_sample <= 0;
    tick(3);
    @(negedge clock);
    chk("rx_refused", 16'h0, {15'h0, rx_valid});
    chk("lanes", 16'hff5a, {bus_data_lines_oe_n[15:8], bus_data_lines_out[7:0]});
    chk("parity", 16'h3, {14'h0, low_byte_parity_out, high_byte_parity_oe_n});
    tick(1);
    {wide_mode, tx_valid, tx_data} <= {2'b11, 16'h7e81};
    tick(12);
    @(negedge clock);
    chk("tx_full", 16'h0, {15'h0, tx_ready});
    chk("wide_lanes", 16'h7e81, bus_data_lines_out);
    chk("wide_oe", 16'h0, bus_data_lines_oe_n);
    chk("wide_parity", 16'h6, {13'h0, high_byte_parity_out, low_byte_parity_out,
      high_byte_parity_oe_n});
    tick(1);
    tx_valid <= 0;
    tick(16);
    @(negedge clock);
    chk("tx_drained", 16'h1, {15'h0, tx_ready});
    tick(1);
    {xfer_out, fdrv} <= 2'b01;
    for (i = 0; i < 12; i++) begin
      target_mode <= i < 6;
      tgt_phase <= i < 6 ? PH[i % 6] : ~PH[i % 6];
      fph <= PH[i % 6];
      tick(4);
      @(negedge clock);
      chk("bus_phase", {13'h0, PH[i % 6]}, {13'h0, bus_phase});
      if (i < 6) chk("lines", {13'h0, PH[i % 6]}, {13'h0, message_phase_line_out,
        phase_cmd_data_line_out, direction_line_out});
      tick(1);
    end
    rst_n <= 0;
    @(negedge clock);
    chk("reset_oe", 16'hffff, bus_data_lines_oe_n);
    chk("reset_ready", 16'h1, {15'h0, tx_ready});
    chk("reset_perr", 16'h0, {15'h0, parity_err});
    chk("reset_rx", 16'h0, {15'h0, rx_valid});
    tick(1);
    rst_n <= 1;
    tick(2);
    finish_test;
  end
endmodule : sbp_pins_bench

// ---- test/sbp_pins_sva.sv ----
// Checker for the bus data phase pin logic
`timescale 1ns/100ps
module sbp_pins_sva (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        target_mode,
  input wire logic        wide_mode,
  input wire logic        xfer_out,
  input wire logic [2:0]  tgt_phase,
  input wire logic [2:0]  bus_phase,
  input wire logic [15:0] bus_data_lines_out,
  input wire logic [15:0] bus_data_lines_oe_n,
  input wire logic        low_byte_parity_out,
  input wire logic        low_byte_parity_oe_n,
  input wire logic        high_byte_parity_out,
  input wire logic        high_byte_parity_oe_n,
  input wire logic        phase_cmd_data_line_out,
  input wire logic        phase_cmd_data_line_oe_n,
  input wire logic        message_phase_line_out,
  input wire logic        message_phase_line_oe_n,
  input wire logic        direction_line_out,
  input wire logic        direction_line_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_narrow_hi_float: assert property (
    !wide_mode [*3] |-> &bus_data_lines_oe_n[15:8] && high_byte_parity_oe_n)
    else $error("high byte driven in narrow mode");
  a_narrow_hi_zero: assert property (
    !wide_mode && !$past(wide_mode) && !bus_data_lines_oe_n[0]
    |-> bus_data_lines_out[15:8] == 8'h00)
    else $error("narrow word has high byte");
  a_low_par_odd: assert property (
    !low_byte_parity_oe_n && !bus_data_lines_oe_n[0]
    |-> low_byte_parity_out == ~^bus_data_lines_out[7:0])
    else $error("low parity not odd");
  a_high_par_odd: assert property (
    !high_byte_parity_oe_n && !bus_data_lines_oe_n[8]
    |-> high_byte_parity_out == ~^bus_data_lines_out[15:8])
    else $error("high parity not odd");
  a_rx_released: assert property (
    !xfer_out [*4] |-> &bus_data_lines_oe_n && low_byte_parity_oe_n)
    else $error("data lines driven while receiving");
  a_init_no_drive: assert property (
    !target_mode [*2] |-> phase_cmd_data_line_oe_n && message_phase_line_oe_n
    && direction_line_oe_n)
    else $error("control line driven as initiator");
  a_tgt_lines: assert property (
    (target_mode && $stable(tgt_phase)) [*4] |-> !phase_cmd_data_line_oe_n
    && {message_phase_line_out, phase_cmd_data_line_out, direction_line_out} == tgt_phase)
    else $error("target phase lines wrong");
  a_tgt_bus_phase: assert property (
    (target_mode && $stable(tgt_phase)) [*3] |-> bus_phase == tgt_phase)
    else $error("bus phase not target phase");
  c_wide_send: cover property (!bus_data_lines_oe_n[15]);
  c_narrow_send: cover property (!wide_mode && !bus_data_lines_oe_n[0]);
  c_cmd_phase: cover property (!phase_cmd_data_line_oe_n && phase_cmd_data_line_out);
endmodule : sbp_pins_sva
bind sbp_pins sbp_pins_sva u_sva (.*);
